// File: ballast_res_model.sv
// behavioural model of the filament sense node and its two comparators
module ballast_res_model import ballast_sup_pkg::*; (
   // clock, lamp presence and source control from the supervisor
   input  wire logic       clk,
   input  wire logic       lamp,
   input  wire logic [2:0] sel,
   input  wire logic       lower,
   input  wire logic       dis,
   // comparator flags
   output logic            over_thr,
   output logic            over_floor
);
   timeunit 1ns;
   timeprecision 100ps;
   int v = 0;
   // millivolts; a present filament clamps the node low except while the delay source charges or the discharge switch drains the capacitor
   always @(posedge clk) begin
      if (dis) begin
         v <= (v > 40) ? v - 40 : 0;
      end else if (sel == SRC_DELAY20 || (!lamp && sel != SRC_OFF)) begin
         v <= (v < 3000) ? v + 20 : v;
      end else begin
         v <= lamp ? 200 : 0;
      end
   end
   assign over_thr   = v > (lower ? 1300 : 1600);
   assign over_floor = v > 375;
endmodule

// File: ballast_startup_fault_supervisor.sv
// start-up sequencer, half-bridge driver and latched fault supervisor of a lamp ballast
//
// Contract
// R1: select 20uA while supply ok and below upper
// R2: above upper: flag open, block, lower threshold, 17uA
// R3: open flagged: below lower means connected, start allowed
// R4: no lamp sink before start: high-side open
// R5: high-side open: 41uA upper, 34uA lower
// R6: after fault, 32 charge/discharge cycles before removal detection
// R7: lamp current beyond 215uA over 610us: fault
// R8: amplitude ratio out of band 500ms: fault
// R9: either fault latches, stop until removal/power cycle
// R10: steady current beyond 175uA also trips
// R11: high-side drive low in high-side lockout
// R12: 1800ns dead time both directions
// R13: filament checks only above 10,5V
// R14: open filament disables until current or lockout
// R15: supply 14V, bus below 15%: power-down wait
// R16: bus above 109%: active, no drive
// R17: start inverter at 125kHz, then timers, boost
// R18: boost on-time ends at 1V, restarts on ZCD
// R19: ignition: first threshold raises frequency
// R20: second threshold stops control, latches fault
// R21: second threshold must persist over 400ns
// R22: first threshold must persist over 250ns
// R23: comparator flags pass two flip-flops
// R24: cycle counts from clock; lockout clears faults
//
// Added by the designer: the AHB-Lite register port and the register addresses.
module ballast_startup_fault_supervisor
   import ballast_sup_pkg::*;
#(
   parameter int unsigned EOL_CYC  = EOL_CYC_DEF,
   parameter int unsigned RECT_CYC = RECT_CYC_DEF
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   // comparator flags, asynchronous
   input  wire logic        VCC_UVLO_OK,
   input  wire logic        VCC_START_OK,
   input  wire logic        RES_OVER_THRESH,
   input  wire logic        RES_OVER_FLOOR,
   input  wire logic        LAMP_VOLTAGE_SENSE_A,
   input  wire logic        LAMP_VOLTAGE_SENSE_B,
   input  wire logic        LVS_EOL_OVER,
   input  wire logic        LVS_DC_OVER,
   input  wire logic        LVS_RATIO_BAD,
   input  wire logic        BUS_OVER_LOW,
   input  wire logic        BUS_OVER_HIGH,
   input  wire logic        HS_SUPPLY_OK,
   input  wire logic        PFC_CS_OVER,
   input  wire logic        PFC_ZCD,
   input  wire logic        INV_CS_OVER1,
   input  wire logic        INV_CS_OVER2,
   // filament restart sense control
   output logic [2:0]       RES_SOURCE_SEL,
   output logic             FILAMENT_LOWER_THRESHOLD,
   output logic             RES_DISCHARGE,
   // drives
   output logic             LOW_SIDE_GATE_DRIVE,
   output logic             HIGH_SIDE_GATE_DRIVE,
   output logic             PFC_GATE_DRIVE,
   output logic             FREQ_STEP_UP,
   output logic             TIMERS_EN,
   // fault flags
   output logic             END_OF_LIFE_OVERVOLTAGE_FAULT,
   output logic             RECTIFIER_EFFECT_FAULT,
   output logic             OVERCURRENT_FAULT,
   // ahb-lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP
);

   // two-stage synchroniser for every comparator flag
   wire  [NSYNC-1:0] async_in = {VCC_UVLO_OK, VCC_START_OK, RES_OVER_THRESH, RES_OVER_FLOOR,
                                 LAMP_VOLTAGE_SENSE_A, LAMP_VOLTAGE_SENSE_B, LVS_EOL_OVER,
                                 LVS_DC_OVER, LVS_RATIO_BAD, BUS_OVER_LOW, BUS_OVER_HIGH,
                                 HS_SUPPLY_OK, PFC_CS_OVER, PFC_ZCD, INV_CS_OVER1, INV_CS_OVER2};
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge CLK) begin
            s1_r[gi] <= RESET_N ? async_in[gi] : 1'b0; // R23
            s2_r[gi] <= RESET_N ? s1_r[gi] : 1'b0; // R23
         end
      end
   endgenerate

   wire vcc_uvlo  = s2_r[15];
   wire vcc_start = s2_r[14];
   wire res_over  = s2_r[13];
   wire res_floor = s2_r[12];
   wire lvs_a     = s2_r[11];
   wire lvs_b     = s2_r[10];
   wire eol_over  = s2_r[9];
   wire dc_over   = s2_r[8];
   wire ratio_bad = s2_r[7];
   wire bus_low   = s2_r[6];
   wire bus_high  = s2_r[5];
   wire hs_ok     = s2_r[4];
   wire pfc_cs    = s2_r[3];
   wire zcd       = s2_r[2];
   wire oc1       = s2_r[1];
   wire oc2       = s2_r[0];

   // state and registers
   sup_state_t        state_r, state_nxt;
   logic [CTRL_W-1:0] ctrl_r;
   logic              ls_open_r, hs_open_r;
   logic              eol_f_r, rect_f_r, oc_f_r;
   logic [15:0]       ph_cnt_r, half_len_r;
   logic              half_r, timers_r, pfc_r, zcd_prev_r;
   logic [5:0]        oc1_cnt_r, oc2_cnt_r;
   logic [31:0]       eol_cnt_r, rect_cnt_r;
   logic [5:0]        rm_cnt_r;
   logic              dis_r;
   logic [2:0]        src_r;
   logic              lower_r, ls_r, hs_r, step_r;

   // filter trips: the condition must persist beyond the stated time
   wire oc1_trip  = oc1_cnt_r == 6'(OC1_CYC);
   wire oc2_trip  = oc2_cnt_r == 6'(OC2_CYC);
   wire eol_trip  = eol_cnt_r == EOL_CYC;
   wire rect_trip = rect_cnt_r == RECT_CYC;
   wire in_run    = state_r == ST_RUN;
   wire ign_mode  = ctrl_r[CTRL_IGN_BIT];
   wire sup_en    = ctrl_r[CTRL_RUN_BIT];
   wire eol_cond  = eol_over | dc_over; // R7 R10
   wire eol_set   = in_run & sup_en & eol_trip; // R7
   wire rect_set  = in_run & sup_en & rect_trip; // R8
   wire oc_active = state_r != ST_LOCKOUT && state_r != ST_FAULT;
   wire oc_set    = oc_active & oc2_trip; // R20 R21
   wire any_trip  = eol_set | rect_set | oc_set;
   wire det_en    = rm_cnt_r == 6'(REMOVAL_CYCLES);
   wire removed   = state_r == ST_FAULT && det_en && res_over;
   wire fil_ok    = !ls_open_r && !hs_open_r && !res_over;
   wire half_end  = ph_cnt_r == half_len_r - 16'h0001;
   wire gate_win  = ph_cnt_r >= 16'(DEAD_CYC);

   // sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_LOCKOUT: if (vcc_uvlo) state_nxt = ST_FILCHK; // R13
         ST_FILCHK:  if (vcc_start && fil_ok) state_nxt = ST_BUSCHK; // R14
         ST_BUSCHK: begin
            if (!bus_low) state_nxt = ST_PWRDN; // R15
            else if (bus_high) state_nxt = ST_OVHOLD; // R16
            else state_nxt = ST_RUN; // R17
         end
         ST_PWRDN:   if (bus_low) state_nxt = ST_BUSCHK; // R15
         ST_OVHOLD:  state_nxt = ST_OVHOLD; // R16
         ST_RUN:     state_nxt = ST_RUN;
         ST_FAULT:   if (removed) state_nxt = ST_FILCHK; // R9
         default:    state_nxt = ST_LOCKOUT;
      endcase
      if (any_trip) state_nxt = ST_FAULT; // R9 R20
      if (!vcc_uvlo) state_nxt = ST_LOCKOUT; // R13
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) state_r <= ST_LOCKOUT;
      else state_r <= state_nxt;
   end

   // filament presence flags
   always_ff @(posedge CLK) begin
      if (!RESET_N || state_r == ST_LOCKOUT) begin
         ls_open_r <= 1'b0;
         hs_open_r <= 1'b0;
      end else if (state_r == ST_FILCHK) begin
         if (!ls_open_r && res_over) ls_open_r <= 1'b1; // R2
         else if (ls_open_r && !res_over) ls_open_r <= 1'b0; // R3
         if (lvs_a || lvs_b) hs_open_r <= 1'b0; // R14
         else if (!vcc_start) hs_open_r <= 1'b1; // R4
      end
   end

   // sense source and threshold selection, registered
   wire [2:0] fil_src = hs_open_r ? (ls_open_r ? SRC_HS34 : SRC_HS41) // R5
                                  : (ls_open_r ? SRC_LS17 : SRC_LS20); // R1 R2
   wire [2:0] src_nxt = state_r == ST_LOCKOUT ? SRC_OFF :
                        state_r == ST_FILCHK  ? fil_src :
                        state_r == ST_FAULT   ? (det_en ? SRC_LS20 : (dis_r ? SRC_OFF : SRC_DELAY20)) : SRC_LS20; // R6 R9
   wire lower_nxt = state_r == ST_FILCHK && ls_open_r;

   // post-fault removal delay: charge to upper, discharge to floor, count
   always_ff @(posedge CLK) begin
      if (!RESET_N || state_r != ST_FAULT) begin
         rm_cnt_r <= 6'h00;
         dis_r    <= 1'b0;
      end else if (!det_en) begin
         if (!dis_r && res_over) dis_r <= 1'b1; // R6
         else if (dis_r && !res_floor) begin
            dis_r    <= 1'b0;
            rm_cnt_r <= rm_cnt_r + 6'h01; // R6
         end
      end
   end

   // latched faults; a power cycle or lamp removal clears them, a new trip wins
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         eol_f_r  <= 1'b0;
         rect_f_r <= 1'b0;
         oc_f_r   <= 1'b0;
      end else begin
         eol_f_r  <= eol_set | (eol_f_r & vcc_uvlo & !removed); // R9 R24
         rect_f_r <= rect_set | (rect_f_r & vcc_uvlo & !removed); // R9 R24
         oc_f_r   <= oc_set | (oc_f_r & vcc_uvlo & !removed); // R20 R24
      end
   end

   // persistence counters, clear as soon as the condition drops
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         oc1_cnt_r  <= 6'h00;
         oc2_cnt_r  <= 6'h00;
         eol_cnt_r  <= 32'h0;
         rect_cnt_r <= 32'h0;
      end else begin
         oc1_cnt_r  <= !oc1 ? 6'h00 : (oc1_trip ? oc1_cnt_r : oc1_cnt_r + 6'h01); // R22
         oc2_cnt_r  <= !oc2 ? 6'h00 : (oc2_trip ? oc2_cnt_r : oc2_cnt_r + 6'h01); // R21
         eol_cnt_r  <= !(eol_cond && in_run) ? 32'h0 : (eol_trip ? eol_cnt_r : eol_cnt_r + 32'h1);
         rect_cnt_r <= !(ratio_bad && in_run) ? 32'h0 : (rect_trip ? rect_cnt_r : rect_cnt_r + 32'h1);
      end
   end

   // ignition step: one pulse per excursion once the filter has run out
   logic step_done_r;
   wire  step_fire = in_run && ign_mode && oc1_trip && !step_done_r; // R19 R22

   // half-bridge timing; each half opens with the dead time
   wire [15:0] half_min = 16'(2 * DEAD_CYC);
   always_ff @(posedge CLK) begin
      if (!RESET_N || !in_run) begin
         ph_cnt_r    <= 16'h0000;
         half_r      <= 1'b0;
         timers_r    <= 1'b0;
         half_len_r  <= 16'(START_HALF_CYC); // R17
         step_done_r <= 1'b0;
      end else begin
         ph_cnt_r    <= half_end ? 16'h0000 : ph_cnt_r + 16'h0001;
         half_r      <= half_end ? !half_r : half_r;
         timers_r    <= timers_r | (half_end & half_r); // R17
         step_done_r <= oc1_trip;
         if (step_fire && half_len_r > half_min + 16'(FREQ_STEP_CYC))
            half_len_r <= half_len_r - 16'(FREQ_STEP_CYC); // R19
      end
   end

   wire ls_nxt = in_run && !any_trip && !half_r && gate_win; // R12
   wire hs_nxt = in_run && !any_trip && half_r && gate_win && hs_ok; // R11 R12

   // boost switch: on-time ends at current limit, next cycle on zero-current edge
   wire zcd_rise = zcd && !zcd_prev_r;
   always_ff @(posedge CLK) begin
      if (!RESET_N || !in_run || !timers_r) begin
         pfc_r      <= 1'b0;
         zcd_prev_r <= 1'b0;
      end else begin
         zcd_prev_r <= zcd;
         if (pfc_r && pfc_cs) pfc_r <= 1'b0; // R18
         else if (!pfc_r && zcd_rise && !pfc_cs) pfc_r <= 1'b1; // R18
      end
   end

   // registered outputs
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         src_r   <= SRC_OFF;
         lower_r <= 1'b0;
         ls_r    <= 1'b0;
         hs_r    <= 1'b0;
         step_r  <= 1'b0;
      end else begin
         src_r   <= src_nxt; // R1 R5
         lower_r <= lower_nxt; // R2
         ls_r    <= ls_nxt;
         hs_r    <= hs_nxt; // R11
         step_r  <= step_fire; // R19
      end
   end

   assign RES_SOURCE_SEL                = src_r;
   assign FILAMENT_LOWER_THRESHOLD      = lower_r;
   assign RES_DISCHARGE                 = dis_r;
   assign LOW_SIDE_GATE_DRIVE           = ls_r;
   assign HIGH_SIDE_GATE_DRIVE          = hs_r;
   assign PFC_GATE_DRIVE                = pfc_r;
   assign FREQ_STEP_UP                  = step_r;
   assign TIMERS_EN                     = timers_r;
   assign END_OF_LIFE_OVERVOLTAGE_FAULT = eol_f_r;
   assign RECTIFIER_EFFECT_FAULT        = rect_f_r;
   assign OVERCURRENT_FAULT             = oc_f_r;

   // ahb-lite slave, zero wait states; status is sampled in the address phase
   logic       wr_ph_r;
   logic [31:0] rdata_r;
   wire         take     = HSEL && HTRANS[1] && HREADY;
   wire         hit_ctrl = HADDR[7:0] == ADDR_CTRL && HADDR[31:8] == 24'h000000;
   wire         hit_stat = HADDR[7:0] == ADDR_STATUS && HADDR[31:8] == 24'h000000;
   wire [31:0]  status_w = (32'(state_r) << ST_STATE_LSB) | (32'(ls_open_r) << ST_LS_OPEN)
                         | (32'(hs_open_r) << ST_HS_OPEN) | (32'(eol_f_r) << ST_EOL)
                         | (32'(rect_f_r) << ST_RECT) | (32'(oc_f_r) << ST_OC)
                         | (32'(timers_r) << ST_TIMERS) | (32'(rm_cnt_r) << ST_RMCNT_LSB);
   wire [31:0]  rd_mux   = hit_ctrl ? 32'(ctrl_r) : (hit_stat ? status_w : 32'h0);

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         wr_ph_r <= 1'b0;
         rdata_r <= 32'h0;
      end else begin
         wr_ph_r <= take && HWRITE && hit_ctrl;
         rdata_r <= (take && !HWRITE) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) ctrl_r <= CTRL_RESET;
      else if (wr_ph_r) ctrl_r <= HWDATA[CTRL_W-1:0];
   end

   assign HRDATA    = rdata_r;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   // checks
   localparam int DEAD_A = DEAD_CYC;
   logic [15:0] gap_r;
   always_ff @(posedge CLK) begin
      if (!RESET_N || ls_r || hs_r) gap_r <= 16'h0000;
      else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   property p_lockout;
      !vcc_uvlo |=> state_r == ST_LOCKOUT;
   endproperty
   a_lockout: assert property (p_lockout) else $error("supply low but not in lockout"); // R13

   property p_ls_open;
      state_r == ST_FILCHK && vcc_uvlo && !ls_open_r && res_over |=> ls_open_r ##1 FILAMENT_LOWER_THRESHOLD;
   endproperty
   a_ls_open: assert property (p_ls_open) else $error("open filament not flagged"); // R2

   property p_ls_close;
      state_r == ST_FILCHK && vcc_uvlo && ls_open_r && !res_over |=> !ls_open_r;
   endproperty
   a_ls_close: assert property (p_ls_close) else $error("connected filament not accepted"); // R3

   property p_src20;
      state_r == ST_FILCHK && !ls_open_r && !hs_open_r |=> RES_SOURCE_SEL == SRC_LS20;
   endproperty
   a_src20: assert property (p_src20) else $error("wrong filament test current"); // R1

   property p_src34;
      state_r == ST_FILCHK && ls_open_r && hs_open_r |=> RES_SOURCE_SEL == SRC_HS34;
   endproperty
   a_src34: assert property (p_src34) else $error("wrong high-side test current"); // R5

   property p_hs_uvlo;
      !hs_ok |=> !HIGH_SIDE_GATE_DRIVE;
   endproperty
   a_hs_uvlo: assert property (p_hs_uvlo) else $error("high side driven in lockout"); // R11

   property p_dead;
      $rose(LOW_SIDE_GATE_DRIVE) || $rose(HIGH_SIDE_GATE_DRIVE) |-> gap_r >= 16'(DEAD_A);
   endproperty
   a_dead: assert property (p_dead) else $error("dead time too short"); // R12

   property p_oc2;
      oc_active && vcc_uvlo && oc2_trip |=> state_r == ST_FAULT && OVERCURRENT_FAULT;
   endproperty
   a_oc2: assert property (p_oc2) else $error("overcurrent not latched"); // R21

   property p_fault_quiet;
      state_r == ST_FAULT && $past(state_r) == ST_FAULT |-> !LOW_SIDE_GATE_DRIVE && !HIGH_SIDE_GATE_DRIVE;
   endproperty
   a_fault_quiet: assert property (p_fault_quiet) else $error("drive active in fault"); // R9

   property p_removal;
      state_r == ST_FAULT && vcc_uvlo && !det_en |=> state_r == ST_FAULT;
   endproperty
   a_removal: assert property (p_removal) else $error("removal detected before delay"); // R6

   property p_eol;
      eol_set && vcc_uvlo |=> END_OF_LIFE_OVERVOLTAGE_FAULT && state_r == ST_FAULT;
   endproperty
   a_eol: assert property (p_eol) else $error("end-of-life fault missed"); // R7

   property p_ovhold;
      state_r == ST_OVHOLD |-> ##1 (!LOW_SIDE_GATE_DRIVE && !HIGH_SIDE_GATE_DRIVE)[*2];
   endproperty
   a_ovhold: assert property (p_ovhold) else $error("drive during bus overvoltage"); // R16

   c_run:     cover property (state_r == ST_BUSCHK ##1 state_r == ST_RUN);
   c_fault:   cover property (in_run ##1 state_r == ST_FAULT);
   c_step:    cover property ($rose(FREQ_STEP_UP));
   c_removal: cover property (state_r == ST_FAULT ##1 state_r == ST_FILCHK);
endmodule

// File: ballast_startup_fault_supervisor_test.sv
// self-checking bench for the ballast start-up and fault supervisor
module ballast_startup_fault_supervisor_test import ballast_sup_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SH[4] = '{30, 30, 150, 30};
   localparam int LG[4] = '{80, 80, 260, 60};
   localparam logic [2:0] EX[4] = '{3'h4, 3'h4, 3'h2, 3'h1};
   logic        clk = 0, rst_n = 0, uvlo_ok = 0, start_ok = 0, sense_a = 0, sense_b = 0, lamp = 1;
   logic        eol = 0, dc = 0, ratio = 0, bus_lo = 0, bus_hi = 0, hs_ok = 1, pfc_cs = 0, zcd = 0;
   logic        oc1 = 0, oc2 = 0, hsel = 0, hwrite = 0, hready, thr, flr, lower, dis, ls, hs, pfc, step;
   logic        tmr, f_eol, f_rect, f_oc;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  sel;
   logic [9:0]  snap;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   int          n_mismatch = 0, num_checks = 0, cyc_n = 0, nstep = 0, ngate = 0, nhs = 0;

   ballast_startup_fault_supervisor #(.EOL_CYC(50), .RECT_CYC(200)) ballast_startup_fault_supervisor_inst (
      .CLK(clk), .RESET_N(rst_n), .VCC_UVLO_OK(uvlo_ok), .VCC_START_OK(start_ok), .RES_OVER_THRESH(thr),
      .RES_OVER_FLOOR(flr), .LAMP_VOLTAGE_SENSE_A(sense_a), .LAMP_VOLTAGE_SENSE_B(sense_b), .LVS_EOL_OVER(eol),
      .LVS_DC_OVER(dc), .LVS_RATIO_BAD(ratio), .BUS_OVER_LOW(bus_lo), .BUS_OVER_HIGH(bus_hi), .HS_SUPPLY_OK(hs_ok),
      .PFC_CS_OVER(pfc_cs), .PFC_ZCD(zcd), .INV_CS_OVER1(oc1), .INV_CS_OVER2(oc2), .RES_SOURCE_SEL(sel),
      .FILAMENT_LOWER_THRESHOLD(lower), .RES_DISCHARGE(dis), .LOW_SIDE_GATE_DRIVE(ls), .HIGH_SIDE_GATE_DRIVE(hs),
      .PFC_GATE_DRIVE(pfc), .FREQ_STEP_UP(step), .TIMERS_EN(tmr), .END_OF_LIFE_OVERVOLTAGE_FAULT(f_eol),
      .RECTIFIER_EFFECT_FAULT(f_rect), .OVERCURRENT_FAULT(f_oc), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
      .HRESP());
   ballast_res_model ballast_res_model_inst (
      .clk(clk), .lamp(lamp), .sel(sel), .lower(lower), .dis(dis), .over_thr(thr), .over_floor(flr));

   initial begin
      forever #5 clk = ~clk;
   end
   // outputs are copied at the falling edge so checks never race the registers
   always @(negedge clk) begin
      snap <= {sel, lower, tmr, ls, hs, f_eol, f_rect, f_oc};
   end
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      nstep <= nstep + (step === 1'b1);
      ngate <= ngate + (ls === 1'b1 || hs === 1'b1);
      nhs <= nhs + (hs === 1'b1);
      if (cyc_n == 60000) begin
         n_mismatch++;
         $display("MISMATCH run time expected below %0d seen %0d", 60000, cyc_n);
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one bus phase: held until hready is seen high at the falling edge before a rising edge
   task automatic ph(output logic [31:0] d);
      logic r;
      do begin
         @(negedge clk);
         r = hready;
         d = hrdata;
         @(posedge clk);
      end while (r !== 1'b1);
   endtask
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      ph(d);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= v;
      ph(d);
   endtask
   task automatic wst(input logic [2:0] s);
      logic [31:0] d;
      for (int i = 0; i < 3000; i++) begin
         xf(1'b0, ADDR_STATUS, 32'h0, d);
         if (d[2:0] === s) break;
      end
      chk("state", s, d[2:0]);
   endtask
   task automatic set(input int k, input logic v);
      case (k)
         0: eol <= v;
         1: dc <= v;
         2: ratio <= v;
         3: oc2 <= v;
         default: oc1 <= v;
      endcase
   endtask
   task automatic pulse(input int k, input int n);
      set(k, 1'b1);
      tick(n);
      set(k, 1'b0);
   endtask
   // counts falling edges until the chosen drive reaches the level
   task automatic tm(input int k, input logic lv, output int n);
      for (n = 0; n < 2000; n++) begin
         @(negedge clk);
         if ((k == 0 ? ls : hs) === lv) break;
      end
      @(posedge clk);
   endtask
   task automatic down();
      uvlo_ok <= 1'b0;
      start_ok <= 1'b0;
      wst(ST_LOCKOUT);
      tick(3);
   endtask
   // the start threshold follows lockout exit, so the filament checks get their cycles
   task automatic up(input logic [2:0] s);
      uvlo_ok <= 1'b1;
      wst(ST_FILCHK);
      start_ok <= 1'b1;
      wst(s);
   endtask

   initial begin
      logic [31:0] d;
      int a, b, g;
      tick(8);
      rst_n <= 1'b1;
      tick(1);
      xf(1'b0, ADDR_CTRL, 32'h0, d);
      chk("ctrl", 32'h0, d);
      xf(1'b0, 8'h08, 32'h0, d);
      chk("unmapped", 32'h0, d);
      chk("outputs", 32'h0, snap);
      wst(ST_LOCKOUT);
      $display("test reset done");
      bus_lo <= 1'b1;
      up(ST_FILCHK);
      tick(40);
      xf(1'b0, ADDR_STATUS, 32'h0, d);
      chk("hs open", 32'h1, d[ST_HS_OPEN]);
      chk("src", SRC_HS41, snap[9:7]);
      lamp <= 1'b0;
      tick(150);
      chk("src", SRC_HS34, snap[9:7]);
      wst(ST_FILCHK);
      lamp <= 1'b1;
      sense_b <= 1'b1;
      wst(ST_RUN);
      $display("test high-side filament done");
      tm(0, 1'b1, a);
      tm(0, 1'b0, a);
      tm(1, 1'b1, g);
      chk("dead", 32'h1, g + 1 >= DEAD_CYC && g < DEAD_CYC + 2);
      tm(1, 1'b0, a);
      tm(0, 1'b1, g);
      chk("dead", 32'h1, g + 1 >= DEAD_CYC && g < DEAD_CYC + 2);
      tm(0, 1'b0, a);
      tm(0, 1'b1, b);
      chk("period", 2 * START_HALF_CYC, a + b + 2);
      chk("timers", 32'h1, snap[5]);
      zcd <= 1'b1;
      tick(6);
      @(negedge clk);
      chk("pfc on", 32'h1, pfc);
      pfc_cs <= 1'b1;
      tick(6);
      @(negedge clk);
      chk("pfc off", 32'h0, pfc);
      zcd <= 1'b0;
      pfc_cs <= 1'b0;
      hs_ok <= 1'b0;
      tick(10);
      a = nhs;
      tick(900);
      chk("hs count", a, nhs);
      hs_ok <= 1'b1;
      $display("test inverter timing done");
      down();
      chk("src", SRC_OFF, snap[9:7]);
      bus_lo <= 1'b0;
      uvlo_ok <= 1'b1;
      wst(ST_FILCHK);
      tick(10);
      chk("src", SRC_LS20, snap[9:7]);
      lamp <= 1'b0;
      tick(150);
      start_ok <= 1'b1;
      tick(10);
      xf(1'b0, ADDR_STATUS, 32'h0, d);
      chk("ls open", 32'h1, d[ST_LS_OPEN]);
      chk("src", {SRC_LS17, 1'b1}, snap[9:6]);
      chk("state", ST_FILCHK, d[2:0]);
      lamp <= 1'b1;
      wst(ST_PWRDN);
      bus_lo <= 1'b1;
      wst(ST_RUN);
      down();
      bus_hi <= 1'b1;
      up(ST_OVHOLD);
      a = ngate;
      tick(100);
      chk("gate count", a, ngate);
      bus_hi <= 1'b0;
      down();
      up(ST_RUN);
      $display("test start-up checks done");
      xf(1'b1, ADDR_CTRL, 32'h3, d);
      a = nstep;
      pulse(4, 20);
      tick(10);
      chk("steps", a, nstep);
      pulse(4, 40);
      tick(10);
      chk("steps", a + 1, nstep);
      $display("test ignition done");
      for (int k = 0; k < 4; k++) begin
         xf(1'b1, ADDR_CTRL, 32'h2, d);
         pulse(k, SH[k]);
         tick(10);
         chk("faults", 32'h0, snap[2:0]);
         pulse(k, LG[k]);
         tick(10);
         chk("faults", EX[k], snap[2:0]);
         chk("gates", 32'h0, snap[4:3]);
         wst(ST_FAULT);
         if (k < 3) begin
            down();
            chk("faults", 32'h0, snap[2:0]);
            up(ST_RUN);
         end
      end
      $display("test faults done");
      lamp <= 1'b0;
      a = cyc_n;
      wst(ST_FILCHK);
      chk("delay", 32'h1, cyc_n - a > 32 * 40);
      chk("faults", 32'h0, snap[2:0]);
      lamp <= 1'b1;
      wst(ST_RUN);
      $display("test removal done");
      close_out();
   end
endmodule

// File: ballast_sup_pkg.sv
// constants, codes and state type shared by the ballast start-up and fault supervisor
package ballast_sup_pkg;
   // clock and timing
   localparam int CLK_MHZ        = 100;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int DEAD_TIME_NS   = 1800;
   localparam int DEAD_CYC       = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OC1_FILT_NS    = 250;
   localparam int OC1_CYC        = (OC1_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OC2_FILT_NS    = 400;
   localparam int OC2_CYC        = (OC2_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EOL_TIME_US    = 610;
   localparam int EOL_CYC_DEF    = EOL_TIME_US * CLK_MHZ;
   localparam int RECT_TIME_MS   = 500;
   localparam int RECT_CYC_DEF   = RECT_TIME_MS * 1000 * CLK_MHZ;
   localparam int START_FREQ_KHZ = 125;
   localparam int START_HALF_CYC = (CLK_MHZ * 1000) / (2 * START_FREQ_KHZ);
   localparam int FREQ_STEP_CYC  = 8;
   localparam int REMOVAL_CYCLES = 32;
   localparam int NSYNC          = 16;

   // register map
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam int CTRL_IGN_BIT  = 0;
   localparam int CTRL_RUN_BIT  = 1;
   localparam int CTRL_W        = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
   localparam int ST_STATE_LSB  = 0;
   localparam int ST_LS_OPEN    = 4;
   localparam int ST_HS_OPEN    = 5;
   localparam int ST_EOL        = 6;
   localparam int ST_RECT       = 7;
   localparam int ST_OC         = 8;
   localparam int ST_TIMERS     = 9;
   localparam int ST_RMCNT_LSB  = 16;

   // filament sense current source selection
   localparam logic [2:0] SRC_OFF     = 3'h0;
   localparam logic [2:0] SRC_LS20    = 3'h1;
   localparam logic [2:0] SRC_LS17    = 3'h2;
   localparam logic [2:0] SRC_HS41    = 3'h3;
   localparam logic [2:0] SRC_HS34    = 3'h4;
   localparam logic [2:0] SRC_DELAY20 = 3'h5;

   typedef enum logic [2:0] {
      ST_LOCKOUT, ST_FILCHK, ST_BUSCHK, ST_PWRDN, ST_OVHOLD, ST_RUN, ST_FAULT
   } sup_state_t;
endpackage
